// File: hdl/pld_top.sv
// Purpose: cable reflectometry, energy detect, downshift, mirroring, test modes
// Assumes: link inputs synchronous to core_clk; strobes one cycle long
// Notes: read data valid the cycle after the read strobe
// Operation
// - reflectometry runs only when partner unplugged or silent
// - after pulse, record arrival time and amplitude of each reflection
// - at most five reflections kept, earliest first
// - cross fault: keep first cross position and at most four reflections
// - auto-trigger bit starts a reflectometry run on link failure
// - result registers readable at any time
// - filtered energy compared with thresholds using hysteresis
// - thresholds and listening periods programmable
// - fast link modes set through config_three
// - downshift to 100M after configurable failed gigabit attempts, default four
// - enhanced mode: one failure without C/D energy downshifts
// - downshift to 10M when gigabit and 100M both fail
// - downshift enabled by strap sampled at reset or register
// - 10/100 mirroring routes A to D and B to C
// - gigabit mirroring swaps A with D and B with C
// - mirroring enabled by strap or config_four bit
// - mirrored pair signals are polarity inverted
// - interrupt output raised on status changes
// - interrupt sources chosen by interrupt_control and interrupt_status
// - config_one field selects normal operation or four test modes: square wave in mode 1, the same LFSR pattern in modes 2 to 4
// - test clock output synchronous to active test pattern
`timescale 1ns/1ns
`default_nettype none
`include "pld_consts.svh"
module pld_top (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  input wire logic link_up,
  input wire logic link_fail,
  input wire logic partner_quiet,
  input wire logic gig_fail,
  input wire logic fe_fail,
  input wire logic cd_energy,
  input wire logic [11:0] energy_lvl,
  input wire logic refl_valid,
  input wire logic refl_cross,
  input wire pld_pkg::pld_refl_t refl_in,
  input wire logic tdr_done,
  input wire logic strap_downshift,
  input wire logic strap_mirror,
  input wire pld_pkg::pld_pair_t tx_in,
  output pld_pkg::pld_pair_t mdi_out,
  output logic tdr_pulse,
  output logic [1:0] speed_sel,
  output logic energy_det,
  output logic [15:0] fast_link_cfg,
  output logic irq_n,
  output logic test_clk
);
  logic [15:0] conf_one_r, conf_three_r, conf_four_r, ictl_r, ists_r, edth_r, edtm_r, dsc_r;
  logic [15:0] rdata_r, ists_nxt, ev;
  pld_pkg::pld_refl_t refl_r [0:4];
  logic [9:0] xpos_r;
  logic [2:0] rcnt_r, rlim;
  logic xseen_r, tdone_r, tfail_r, str_done_r, str_ds_r, str_mir_r;
  pld_pkg::pld_tdr_st_t tst_r;
  pld_pkg::pld_speed_t spd_r;
  logic [2:0] fcnt_r, tm;
  logic [11:0] filt_r;
  logic signed [12:0] fdiff;
  logic [7:0] lcnt_r, lfsr_pat;
  logic ed_r, link_q_r, tclk_r, test_on, ds_en, mir_en, wr_ctl, rd_sts;
  logic [10:0] lfsr_r;
  logic [3:0] ph_r;
  pld_pkg::pld_pair_t mout;
  logic speed_chg_r, ed_q_r;
  pld_pkg::pld_speed_t spd_q_r;

  // polarity inversion of one pair symbol
  function automatic logic [7:0] inv8(input logic [7:0] x);
    inv8 = 8'(~x + 8'h01);
  endfunction

  // register hit decode
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    hit = (a == b);
  endfunction

  assign rd_sts = reg_rd && hit(reg_addr, `PLD_A_ISTS);
  assign wr_ctl = reg_wr && hit(reg_addr, `PLD_A_TDRC);
  assign tm = conf_one_r[`PLD_B_TM_HI:`PLD_B_TM_LO];
  assign test_on = (tm != 3'h0) && (tm <= `PLD_TM_MAX);
  assign ds_en = str_ds_r | dsc_r[`PLD_B_DSEN];
  assign mir_en = str_mir_r | conf_four_r[`PLD_B_MIRR];
  assign fast_link_cfg = conf_three_r;
  assign speed_sel = spd_r;
  assign energy_det = ed_r;
  assign reg_rdata = rdata_r;
  assign test_clk = tclk_r;
  assign tdr_pulse = (tst_r == pld_pkg::T_PULSE);
  assign irq_n = ~|(ists_r & ictl_r);

  // straps caught once, on the first edge after reset release
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      str_done_r <= 1'b0;
      str_ds_r <= 1'b0;
      str_mir_r <= 1'b0;
    end else if (!str_done_r) begin
      str_done_r <= 1'b1;
      str_ds_r <= strap_downshift;
      str_mir_r <= strap_mirror;
    end
  end

  // software-written configuration
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      conf_one_r <= `PLD_CONF_ONE_RST;
      conf_three_r <= `PLD_CONF_THREE_RST;
      conf_four_r <= `PLD_CONF_FOUR_RST;
      ictl_r <= `PLD_ICTL_RST;
      edth_r <= `PLD_EDTH_RST;
      edtm_r <= `PLD_EDTM_RST;
      dsc_r <= `PLD_DSC_RST;
    end else if (reg_wr) begin
      if (hit(reg_addr, `PLD_A_CONF_ONE)) begin
        conf_one_r <= reg_wdata;
      end else if (hit(reg_addr, `PLD_A_CONF_THREE)) begin
        conf_three_r <= reg_wdata;
      end else if (hit(reg_addr, `PLD_A_CONF_FOUR)) begin
        conf_four_r <= reg_wdata;
      end else if (hit(reg_addr, `PLD_A_ICTL)) begin
        ictl_r <= reg_wdata;
      end else if (hit(reg_addr, `PLD_A_EDTH)) begin
        edth_r <= reg_wdata;
      end else if (hit(reg_addr, `PLD_A_EDTM)) begin
        edtm_r <= reg_wdata;
      end else if (hit(reg_addr, `PLD_A_DSC)) begin
        dsc_r <= reg_wdata;
      end
    end
  end

  // read mux, results readable in any state
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rdata_r <= 16'h0000;
    end else if (reg_rd) begin
      if (hit(reg_addr, `PLD_A_CONF_ONE)) begin
        rdata_r <= conf_one_r;
      end else if (hit(reg_addr, `PLD_A_ICTL)) begin
        rdata_r <= ictl_r;
      end else if (hit(reg_addr, `PLD_A_ISTS)) begin
        rdata_r <= ists_r;
      end else if (hit(reg_addr, `PLD_A_CONF_THREE)) begin
        rdata_r <= conf_three_r;
      end else if (hit(reg_addr, `PLD_A_CONF_FOUR)) begin
        rdata_r <= conf_four_r;
      end else if (hit(reg_addr, `PLD_A_TDRC)) begin
        rdata_r <= {6'h00, spd_r, ed_r, rcnt_r, xseen_r, tfail_r, tdone_r,
                    tst_r != pld_pkg::T_IDLE};
      end else if (hit(reg_addr, `PLD_A_XPOS)) begin
        rdata_r <= {6'h00, xpos_r};
      end else if (reg_addr >= `PLD_A_REFL0 && reg_addr <= `PLD_A_REFL4) begin
        rdata_r <= refl_r[3'(reg_addr - `PLD_A_REFL0)];
      end else if (hit(reg_addr, `PLD_A_EDTH)) begin
        rdata_r <= edth_r;
      end else if (hit(reg_addr, `PLD_A_EDTM)) begin
        rdata_r <= edtm_r;
      end else if (hit(reg_addr, `PLD_A_DSC)) begin
        rdata_r <= dsc_r;
      end else begin
        rdata_r <= 16'h0000;
      end
    end else begin
      rdata_r <= 16'h0000;
    end
  end

  // reflectometry sequencer
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      tst_r <= pld_pkg::T_IDLE;
      tdone_r <= 1'b0;
      tfail_r <= 1'b0;
    end else begin
      case (tst_r)
        pld_pkg::T_IDLE: begin
          if ((wr_ctl && reg_wdata[`PLD_B_START]) ||
              (link_fail && conf_one_r[`PLD_B_AUTO])) begin
            tst_r <= pld_pkg::T_CHECK;
            tdone_r <= 1'b0;
            tfail_r <= 1'b0;
          end
        end
        pld_pkg::T_CHECK: begin
          if (partner_quiet && !link_up) begin
            tst_r <= pld_pkg::T_PULSE;
          end else begin
            tst_r <= pld_pkg::T_IDLE;
            tfail_r <= 1'b1;
          end
        end
        pld_pkg::T_PULSE: begin
          tst_r <= pld_pkg::T_LISTEN;
        end
        default: begin
          if (tdr_done) begin
            tst_r <= pld_pkg::T_IDLE;
            tdone_r <= 1'b1;
          end
        end
      endcase
    end
  end

  // reflection capture, earliest kept
  assign rlim = xseen_r ? `PLD_REFL_MAX_X : `PLD_REFL_MAX;
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      rcnt_r <= 3'h0;
      xseen_r <= 1'b0;
      xpos_r <= 10'h000;
      for (int i = 0; i < 5; i++) begin
        refl_r[i] <= '0;
      end
    end else if (tst_r == pld_pkg::T_PULSE) begin
      rcnt_r <= 3'h0;
      xseen_r <= 1'b0;
    end else if (tst_r == pld_pkg::T_LISTEN && refl_valid) begin
      if (refl_cross) begin
        if (!xseen_r) begin
          xseen_r <= 1'b1;
          xpos_r <= refl_in.tim;
          if (rcnt_r > `PLD_REFL_MAX_X) begin
            rcnt_r <= `PLD_REFL_MAX_X;
          end
        end
      end else if (rcnt_r < rlim) begin
        refl_r[rcnt_r] <= refl_in;
        rcnt_r <= rcnt_r + 3'h1;
      end
    end
  end

  // iir energy filter and hysteresis detector
  assign fdiff = $signed({1'b0, energy_lvl}) - $signed({1'b0, filt_r});
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      filt_r <= 12'h000;
      ed_r <= 1'b0;
      lcnt_r <= 8'h00;
    end else begin
      filt_r <= 12'($signed({1'b0, filt_r}) + (fdiff >>> `PLD_IIR_SH));
      if (!ed_r && filt_r[11:4] >= edth_r[15:8]) begin
        if (lcnt_r >= edtm_r[15:8]) begin
          ed_r <= 1'b1;
          lcnt_r <= 8'h00;
        end else begin
          lcnt_r <= lcnt_r + 8'h01;
        end
      end else if (ed_r && filt_r[11:4] < edth_r[7:0]) begin
        if (lcnt_r >= edtm_r[7:0]) begin
          ed_r <= 1'b0;
          lcnt_r <= 8'h00;
        end else begin
          lcnt_r <= lcnt_r + 8'h01;
        end
      end else begin
        lcnt_r <= 8'h00;
      end
    end
  end

  // speed downshift
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      spd_r <= pld_pkg::SPD_1000;
      fcnt_r <= 3'h0;
    end else if (!ds_en) begin
      spd_r <= pld_pkg::SPD_1000;
      fcnt_r <= 3'h0;
    end else if (link_up) begin
      fcnt_r <= 3'h0;
    end else if (gig_fail && spd_r == pld_pkg::SPD_1000) begin
      if ((dsc_r[`PLD_B_DSENH] && !cd_energy) ||
          fcnt_r + 3'h1 >= dsc_r[`PLD_B_DSC_HI:`PLD_B_DSC_LO]) begin
        spd_r <= pld_pkg::SPD_100;
        fcnt_r <= 3'h0;
      end else begin
        fcnt_r <= fcnt_r + 3'h1;
      end
    end else if (fe_fail && spd_r == pld_pkg::SPD_100) begin
      spd_r <= pld_pkg::SPD_10;
    end
  end

  // sticky status, read clears, a new event wins
  always_comb begin
    ev = 16'h0000;
    ev[`PLD_I_LINK] = link_up ^ link_q_r;
    ev[`PLD_I_SPD] = 1'b0;
    ev[`PLD_I_ED] = 1'b0;
    ev[`PLD_I_TDR] = (tst_r == pld_pkg::T_LISTEN) && tdr_done;
    ists_nxt = (rd_sts ? 16'h0000 : ists_r) | ev;
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      ists_r <= 16'h0000;
      link_q_r <= 1'b0;
    end else begin
      ists_r <= ists_nxt;
      ists_r[`PLD_I_SPD] <= ists_nxt[`PLD_I_SPD] | (speed_chg_r);
      ists_r[`PLD_I_ED] <= ists_nxt[`PLD_I_ED] | (ed_r ^ ed_q_r);
      link_q_r <= link_up;
    end
  end
  // delayed copies for change events
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      spd_q_r <= pld_pkg::SPD_1000;
      ed_q_r <= 1'b0;
      speed_chg_r <= 1'b0;
    end else begin
      spd_q_r <= spd_r;
      ed_q_r <= ed_r;
      speed_chg_r <= (spd_r != spd_q_r);
    end
  end

  // test pattern source and its clock
  always_ff @(posedge core_clk) begin
    if (!rst_n || !test_on) begin
      tclk_r <= 1'b0;
      lfsr_r <= `PLD_LFSR_RST;
      ph_r <= 4'h0;
    end else begin
      tclk_r <= ~tclk_r;
      if (!tclk_r) begin
        lfsr_r <= {lfsr_r[9:0], lfsr_r[10] ^ lfsr_r[8]};
        ph_r <= ph_r + 4'h1;
      end
    end
  end
  assign lfsr_pat = (tm == 3'h1) ? (ph_r[3] ? `PLD_TM1_HI : `PLD_TM1_LO)
                                 : lfsr_r[7:0];

  // pair mapping with mirroring and inversion
  always_comb begin
    mout = tx_in;
    if (test_on) begin
      mout = {4{lfsr_pat}};
    end else if (mir_en && spd_r == pld_pkg::SPD_1000) begin
      mout.a = inv8(tx_in.d);
      mout.b = inv8(tx_in.c);
      mout.c = inv8(tx_in.b);
      mout.d = inv8(tx_in.a);
    end else if (mir_en) begin
      mout.a = 8'h00;
      mout.b = 8'h00;
      mout.c = inv8(tx_in.b);
      mout.d = inv8(tx_in.a);
    end
  end
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      mdi_out <= '0;
    end else begin
      mdi_out <= mout;
    end
  end

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);

  chk_tdr_gate: assert property (tst_r == pld_pkg::T_PULSE |->
    $past(partner_quiet) && !$past(link_up)) else $error("pulse while link busy");
  chk_refl_limit: assert property (xseen_r |-> rcnt_r <= 3'h4)
    else $error("too many reflections with cross fault");
  chk_refl_cap: assert property (rcnt_r <= 3'h5)
    else $error("more than five reflections");
  chk_refl_store: assert property (tst_r == pld_pkg::T_LISTEN && refl_valid
    && !refl_cross && rcnt_r < rlim |=> rcnt_r == $past(rcnt_r) + 3'h1)
    else $error("reflection not stored");
  chk_auto_start: assert property (tst_r == pld_pkg::T_IDLE && link_fail
    && conf_one_r[7] |=> tst_r == pld_pkg::T_CHECK) else $error("auto run missing");
  chk_ed_hyst: assert property ($rose(ed_r) |->
    $past(filt_r[11:4] >= edth_r[15:8])) else $error("detect without threshold");
  chk_ds_count: assert property (ds_en && !link_up && gig_fail &&
    spd_r == pld_pkg::SPD_1000 && fcnt_r + 3'h1 == dsc_r[4:2]
    |=> spd_r == pld_pkg::SPD_100) else $error("downshift missed");
  chk_ds_enh: assert property (ds_en && !link_up && gig_fail && dsc_r[1]
    && !cd_energy && spd_r == pld_pkg::SPD_1000 |=> spd_r == pld_pkg::SPD_100)
    else $error("enhanced downshift missed");
  chk_ds_ten: assert property (ds_en && !link_up && fe_fail &&
    spd_r == pld_pkg::SPD_100 |=> spd_r == pld_pkg::SPD_10)
    else $error("10M fallback missed");
  chk_ds_clear: assert property (link_up |=> fcnt_r == 3'h0)
    else $error("fail count kept");
  chk_mirror_gig: assert property (mir_en && !test_on &&
    spd_r == pld_pkg::SPD_1000 |=> mdi_out.a == inv8($past(tx_in.d)))
    else $error("gigabit mirror wrong");
  chk_test_clk: assert property (test_on && $past(test_on) |->
    tclk_r != $past(tclk_r)) else $error("test clock stalled");
endmodule // pld_top
`default_nettype wire

// File: hdl/pld_consts.svh
// Purpose: addresses, field positions and reset values of the link diagnostics block
// Assumes: 8-bit management address, 16-bit registers
// Notes: included by the block and its bench
`ifndef PLD_CONSTS_SVH
`define PLD_CONSTS_SVH
// register addresses
`define PLD_A_CONF_ONE 8'h09
`define PLD_A_ICTL 8'h12
`define PLD_A_ISTS 8'h13
`define PLD_A_CONF_THREE 8'h1E
`define PLD_A_CONF_FOUR 8'h31
`define PLD_A_TDRC 8'h40
`define PLD_A_XPOS 8'h41
`define PLD_A_REFL0 8'h42
`define PLD_A_REFL4 8'h46
`define PLD_A_EDTH 8'h47
`define PLD_A_EDTM 8'h48
`define PLD_A_DSC 8'h49
// field positions
`define PLD_B_AUTO 7
`define PLD_B_TM_HI 15
`define PLD_B_TM_LO 13
`define PLD_B_MIRR 0
`define PLD_B_START 0
`define PLD_B_DSEN 0
`define PLD_B_DSENH 1
`define PLD_B_DSC_HI 4
`define PLD_B_DSC_LO 2
// interrupt source bits
`define PLD_I_LINK 0
`define PLD_I_SPD 1
`define PLD_I_ED 2
`define PLD_I_TDR 3
// reset values
`define PLD_CONF_ONE_RST 16'h0000
`define PLD_CONF_THREE_RST 16'h0000
`define PLD_CONF_FOUR_RST 16'h0000
`define PLD_ICTL_RST 16'h0000
`define PLD_EDTH_RST 16'h3010
`define PLD_EDTM_RST 16'h1010
`define PLD_DSC_RST 16'h0010
// limits and constants
`define PLD_REFL_MAX 3'h5
`define PLD_REFL_MAX_X 3'h4
`define PLD_IIR_SH 3
`define PLD_TM_MAX 3'h4
`define PLD_TM1_HI 8'h40
`define PLD_TM1_LO 8'hC0
`define PLD_LFSR_RST 11'h7FF
`endif

// File: hdl/pld_pkg.sv
// Purpose: types of the link diagnostics block
// Assumes: nothing
// Notes: constants live in pld_consts.svh
package pld_pkg;
  // one symbol per twisted pair
  typedef struct packed {
    logic [7:0] a;
    logic [7:0] b;
    logic [7:0] c;
    logic [7:0] d;
  } pld_pair_t;
  // one stored reflection
  typedef struct packed {
    logic [9:0] tim;
    logic [5:0] amp;
  } pld_refl_t;
  typedef enum logic [1:0] {T_IDLE, T_CHECK, T_PULSE, T_LISTEN} pld_tdr_st_t;
  typedef enum logic [1:0] {SPD_10, SPD_100, SPD_1000} pld_speed_t;
endpackage

// File: verif/pld_partner.sv
// Purpose: far-side echo source for the link diagnostics block
// Assumes: one echo per cycle after the pulse, then a done pulse
// Notes: idle return lines show the inverse of their last value
`timescale 1ns/1ns
`default_nettype none
module pld_partner (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic tdr_pulse,
  input wire logic [3:0] n_refl,
  input wire logic [3:0] cross_at,
  output logic refl_valid,
  output logic refl_cross,
  output pld_pkg::pld_refl_t refl_in,
  output logic tdr_done
);
  logic busy_r;
  logic [3:0] k_r;
  // answer each pulse with n_refl echoes, then finish listening
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      k_r <= 4'h0;
      refl_valid <= 1'b0;
      refl_cross <= 1'b0;
      refl_in <= '0;
      tdr_done <= 1'b0;
    end else if (tdr_pulse) begin
      busy_r <= 1'b1;
      k_r <= 4'h0;
    end else if (busy_r && k_r < n_refl) begin
      refl_valid <= 1'b1;
      refl_cross <= (k_r == cross_at);
      refl_in <= {10'(k_r) * 10'h028 + 10'h008, 6'(k_r) + 6'h01};
      k_r <= k_r + 4'h1;
    end else begin
      refl_valid <= 1'b0;
      refl_cross <= ~refl_cross; // released lines wander
      refl_in <= ~refl_in;
      tdr_done <= busy_r;
      busy_r <= 1'b0;
    end
  end
endmodule // pld_partner
`default_nettype wire

// File: verif/tb.sv
// Purpose: self-checking bench of the link diagnostics block
// Assumes: registered read data one cycle after the read strobe
// Notes: echo timing is raw, distance is left to the host
`timescale 1ns/1ns
`default_nettype none
`include "pld_consts.svh"
module tb;
  logic core_clk, rst_n, reg_wr, reg_rd, link_up, link_fail, partner_quiet;
  logic gig_fail, fe_fail, cd_energy, refl_valid, refl_cross, tdr_done;
  logic tdr_pulse, energy_det, irq_n, test_clk, t0, strap_ds, strap_mir;
  logic [7:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, fast_link_cfg, rv;
  logic [11:0] energy_lvl;
  logic [1:0] speed_sel;
  logic [3:0] n_refl, cross_at;
  logic [31:0] rnd;
  pld_pkg::pld_refl_t refl_in;
  pld_pkg::pld_pair_t tx_in, mdi_out, ep;
  int mismatches, check_count, pulses;
  logic [15:0] exp_q[$];
  logic [7:0] ra[8] = '{`PLD_A_CONF_ONE, `PLD_A_ICTL, `PLD_A_CONF_THREE, `PLD_A_CONF_FOUR,
    `PLD_A_EDTH, `PLD_A_EDTM, `PLD_A_DSC, 8'h00};
  logic [15:0] rx[8] = '{16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h3010, 16'h1010,
    16'h0010, 16'h0000};

  pld_top dut (.core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .link_up(link_up),
    .link_fail(link_fail), .partner_quiet(partner_quiet), .gig_fail(gig_fail),
    .fe_fail(fe_fail), .cd_energy(cd_energy), .energy_lvl(energy_lvl),
    .refl_valid(refl_valid), .refl_cross(refl_cross), .refl_in(refl_in), .tdr_done(tdr_done),
    .strap_downshift(strap_ds), .strap_mirror(strap_mir), .tx_in(tx_in), .mdi_out(mdi_out),
    .tdr_pulse(tdr_pulse), .speed_sel(speed_sel), .energy_det(energy_det),
    .fast_link_cfg(fast_link_cfg), .irq_n(irq_n), .test_clk(test_clk));
  pld_partner partner (.core_clk(core_clk), .rst_n(rst_n), .tdr_pulse(tdr_pulse),
    .n_refl(n_refl), .cross_at(cross_at), .refl_valid(refl_valid), .refl_cross(refl_cross),
    .refl_in(refl_in), .tdr_done(tdr_done));

  // clock and pulse counter
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  always @(posedge core_clk) if (tdr_pulse === 1'b1) pulses++;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask
  task automatic pulse_in(input int w, input int n);
    repeat (n) begin
      @(posedge core_clk);
      case (w)
        0: gig_fail <= 1'b1;
        1: fe_fail <= 1'b1;
        2: link_up <= 1'b1;
        default: link_fail <= 1'b1;
      endcase
      @(posedge core_clk);
      {gig_fail, fe_fail, link_up, link_fail} <= 4'h0;
    end
  endtask
  // one reflectometry run against the echo model
  task automatic tdr_run(input int n, input int xa, input int ok, input int auto);
    int p0;
    logic [15:0] st;
    n_refl <= 4'(n);
    cross_at <= 4'(xa);
    p0 = pulses;
    if (auto) pulse_in(3, 1);
    else wr(`PLD_A_TDRC, 16'h0001);
    repeat (60) begin
      rd(`PLD_A_TDRC, st);
      if (st[0] === 1'b0) break;
    end
    if (st[0] !== 1'b0) begin
      mismatches++;
      final_report;
    end
    check("tdr pulse count", 32'(pulses - p0), 32'(ok));
    check("tdr fail flag", st[2], !ok);
    check("tdr done flag", st[1], ok);
    exp_q.delete();
    for (int k = 0; k < n && ok; k++) begin
      if (k != xa && exp_q.size() < ((xa < n) ? 4 : 5)) begin
        exp_q.push_back({10'(k * 40 + 8), 6'(k + 1)});
      end
    end
    if (ok) begin
      check("tdr count", st[6:4], exp_q.size());
      check("tdr cross flag", st[3], xa < n);
      if (xa < n) begin
        rd(`PLD_A_XPOS, rv);
        check("cross position", rv, 32'(xa * 40 + 8));
      end
      foreach (exp_q[i]) begin
        rd(8'(`PLD_A_REFL0 + i), rv);
        check("reflection", rv, exp_q[i]);
      end
    end
    $display("test reflectometry done");
  endtask
  // pair routing for mode 0 plain, 1 fast mirror, 2 gigabit mirror
  task automatic mirr(input int m);
    rnd = lfsr(rnd);
    @(posedge core_clk);
    tx_in <= rnd;
    cyc(2);
    ep = (m == 0) ? rnd : {-rnd[7:0], -rnd[15:8], -rnd[23:16], -rnd[31:24]};
    if (m == 1) ep = {16'h0000, -rnd[23:16], -rnd[31:24]};
    check("pair outputs", mdi_out, ep);
  endtask
  task automatic wait_det(input logic v);
    repeat (200) begin
      cyc(1);
      if (energy_det === v) break;
    end
    if (energy_det !== v) begin
      mismatches++;
      final_report;
    end
  endtask

  // main sequence
  initial begin
    {rst_n, reg_wr, reg_rd, link_up, link_fail, gig_fail, fe_fail, strap_ds, strap_mir} = 9'h000;
    {reg_addr, reg_wdata, energy_lvl, tx_in} = '0;
    {partner_quiet, cd_energy, n_refl, cross_at} = 10'h30F;
    rnd = 32'h82AFFE75;
    {mismatches, check_count, pulses} = '0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(2);
    check("reset outputs", {speed_sel, irq_n, test_clk, energy_det}, 5'h14);
    for (int i = 0; i < 8; i++) begin
      rd(ra[i], rv);
      check("reset value", rv, rx[i]);
    end
    rnd = lfsr(rnd);
    wr(`PLD_A_CONF_THREE, rnd[15:0]);
    wr(8'h00, 16'hFFFF);
    wr(`PLD_A_ISTS, 16'hFFFF);
    rd(`PLD_A_CONF_THREE, rv);
    check("config_three", rv, rnd[15:0]);
    check("fast link cfg", fast_link_cfg, rnd[15:0]);
    rd(8'h00, rv);
    check("unmapped", rv, 16'h0000);
    rd(`PLD_A_ISTS, rv);
    check("status read only", rv, 16'h0000);
    $display("test registers done");
    wr(`PLD_A_ICTL, 16'h0008);
    tdr_run(7, 15, 1, 0);
    check("irq raised", irq_n, 1'b0);
    wr(`PLD_A_ICTL, 16'h0000);
    cyc(1);
    check("irq masked", irq_n, 1'b1);
    rd(`PLD_A_ISTS, rv);
    check("status tdr", rv[3], 1'b1);
    wr(`PLD_A_ICTL, 16'h0008);
    cyc(1);
    check("irq cleared", irq_n, 1'b1);
    wr(`PLD_A_REFL0, 16'hFFFF);
    rd(`PLD_A_REFL0, rv);
    check("result read only", rv, exp_q[0]);
    tdr_run(6, 1, 1, 0);
    partner_quiet <= 1'b0;
    tdr_run(3, 15, 0, 0);
    partner_quiet <= 1'b1;
    pulses = 0;
    pulse_in(3, 1);
    cyc(5);
    check("no auto run", pulses, 0);
    wr(`PLD_A_CONF_ONE, 16'h0080);
    tdr_run(2, 15, 1, 1);
    wr(`PLD_A_CONF_ONE, 16'h0000);
    wr(`PLD_A_DSC, 16'h0011);
    pulse_in(0, 3);
    pulse_in(2, 1);
    pulse_in(0, 3);
    cyc(3);
    check("speed after clear", speed_sel, 2'h2);
    pulse_in(0, 1);
    cyc(3);
    check("speed downshift", speed_sel, 2'h1);
    wr(`PLD_A_CONF_FOUR, 16'h0001);
    mirr(1);
    pulse_in(1, 1);
    cyc(3);
    check("speed 10M", speed_sel, 2'h0);
    wr(`PLD_A_DSC, 16'h0000);
    cyc(3);
    check("speed disabled", speed_sel, 2'h2);
    mirr(2);
    cd_energy <= 1'b0;
    wr(`PLD_A_DSC, 16'h0013);
    pulse_in(0, 1);
    cyc(3);
    check("speed enhanced", speed_sel, 2'h1);
    wr(`PLD_A_DSC, 16'h0000);
    wr(`PLD_A_CONF_FOUR, 16'h0000);
    mirr(0);
    $display("test downshift and mirror done");
    for (int m = 1; m < 5; m++) begin
      wr(`PLD_A_CONF_ONE, 16'(m << 13));
      cyc(3);
      t0 = test_clk;
      cyc(1);
      check("test clock", {t0, test_clk}, {t0, ~t0});
      if (m == 1) check("square", mdi_out.a == 8'h40 || mdi_out.a == 8'hC0, 1);
      else check("lfsr pairs", {mdi_out.b, mdi_out.c, mdi_out.d}, {3{mdi_out.a}});
    end
    wr(`PLD_A_CONF_ONE, 16'hA000);
    cyc(3);
    check("test clock idle", test_clk, 1'b0);
    mirr(0);
    $display("test patterns done");
    energy_lvl <= 12'h200;
    cyc(40);
    check("energy stays off", energy_det, 1'b0);
    energy_lvl <= 12'hFFF;
    wait_det(1'b1);
    energy_lvl <= 12'h200;
    cyc(40);
    check("energy stays on", energy_det, 1'b1);
    energy_lvl <= 12'h000;
    wait_det(1'b0);
    wr(`PLD_A_EDTH, 16'h1810);
    energy_lvl <= 12'h200;
    wait_det(1'b1);
    check("energy threshold", energy_det, 1'b1);
    $display("test energy done");
    // second reset in mid-run, straps high until they are caught
    @(posedge core_clk);
    strap_ds <= 1'b1;
    strap_mir <= 1'b1;
    rst_n <= 1'b0;
    repeat (10) @(posedge core_clk);
    rst_n <= 1'b1;
    cyc(2);
    check("second reset outputs", {speed_sel, irq_n, test_clk, energy_det}, 5'h14);
    @(posedge core_clk);
    strap_ds <= 1'b0;
    strap_mir <= 1'b0;
    mirr(2);
    pulse_in(0, 4);
    cyc(3);
    check("strap downshift", speed_sel, 2'h1);
    $display("test straps done");
    final_report;
  end
endmodule // tb
`default_nettype wire
